//--- design/tsb_pkg.sv
// Purpose: constants and types of the test and skip branch unit
// Assumes: one machine cycle is one aclk cycle
// Notes: opcodes are {sign, eleven code bits}; sign 1 means minus
package tsb_pkg;

  // field widths
  localparam int OPC_W = 12;
  localparam int ADR_W = 15;
  localparam int CH_N = 8;

  // operation codes
  localparam logic [11:0] OP_IND_PLUS = 12'h1F0;
  localparam logic [11:0] OP_IND_MINUS = 12'h9F0;
  localparam logic [11:0] OP_ZERO = 12'h150;
  localparam logic [11:0] OP_NONZERO = 12'h950;
  localparam logic [11:0] OP_ARITH = 12'h0E0;
  localparam logic [11:0] OP_LOGIC = 12'h8E0;
  // channel transfer families, code bits 10..3, 10..2 or 10..0
  localparam logic [7:0] OP_BUSY_HI = 8'h06;
  localparam logic [8:0] OP_EOF_HI = 9'h006;
  localparam logic [10:0] OP_RC_0 = 11'h012;
  localparam logic [10:0] OP_RC_1 = 11'h014;
  localparam logic [10:0] OP_RC_2 = 11'h016;
  localparam logic [10:0] OP_RC_3 = 11'h017;

  // indicator test addresses
  localparam logic [14:0] AD_IO = 15'h0005;
  localparam logic [14:0] AD_PBIT = 15'h0001;
  localparam logic [14:0] AD_LBIT = 15'h0001;
  localparam logic [14:0] AD_DIV = 15'h000A;
  localparam logic [8:0] AD_CH_LOW = 9'h000;
  localparam logic [5:0] AD_CH_MIN = 6'h01;
  localparam logic [5:0] AD_CH_MAX = 6'h08;

  // execution lengths in machine cycles
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // outcome codes
  localparam logic [1:0] OUT_SEQ = 2'h0;
  localparam logic [1:0] OUT_SKIP1 = 2'h1;
  localparam logic [1:0] OUT_SKIP2 = 2'h2;
  localparam logic [1:0] OUT_BRANCH = 2'h3;

  // register map and fields
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_IND = 8'h04;
  localparam logic [7:0] R_CHAN = 8'h08;
  localparam int CTL_SEL_TRAP = 0;
  localparam int CTL_COPY_TRAP = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {S_IDLE, S_EXEC} tsb_state_t;

  typedef enum logic [3:0] {
    K_NONE, K_END_TAPE, K_IO_CHECK, K_P_BIT, K_LOW_BIT, K_DIV_CHECK,
    K_ZERO, K_NONZERO, K_ARITH, K_LOGIC, K_CH_BUSY, K_CH_IDLE,
    K_REDUND, K_EOF
  } tsb_kind_t;

  typedef struct packed {
    tsb_state_t st;
    tsb_kind_t kind;
    logic [2:0] chan;
    logic [14:0] loc;
    logic [14:0] ea;
    logic [1:0] len;
    logic [1:0] cnt;
    logic need;
    logic have;
    logic [35:0] sword;
    logic stor_req;
    logic done;
    logic unhandled;
    logic [1:0] outcome;
    logic [14:0] next_ic;
    logic io_chk;
    logic div_chk;
    logic [7:0] eot;
    logic [7:0] eof;
    logic [7:0] tchk;
    logic [1:0] ctrl;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tsb_regs_t;

  localparam tsb_regs_t TSB_RST = '0;

endpackage : tsb_pkg

//--- design/tsb_unit.sv
// Purpose: executes indicator tests, storage tests, compares and
//   channel conditional transfers, returning the next location
// Assumes: operands and channel events are on aclk; address is
//   already index modified when the instruction is issued
// Notes: one machine cycle is one aclk cycle
//
// Added by the designer: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module tsb_unit
  import tsb_pkg::*;
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // instruction issue
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic [11:0] ins_opcode,
  input wire logic [14:0] ins_addr,
  input wire logic [14:0] ins_loc,
  // result
  output logic done,
  output logic [14:0] next_ic,
  output logic [1:0] outcome,
  output logic unhandled,
  // operands
  input wire logic [37:0] ac_word,
  output logic stor_req,
  output logic [14:0] stor_addr,
  input wire logic stor_rvalid,
  input wire logic [35:0] stor_rdata,
  // data channels
  input wire logic [7:0] chan_busy,
  input wire logic [7:0] chan_wr_active,
  input wire logic [7:0] chan_marker,
  input wire logic [7:0] chan_eof_set,
  input wire logic [7:0] chan_tchk_set,
  input wire logic [7:0] chan_underrun,
  input wire logic [7:0] chan_overrun,
  input wire logic chan_load_evt,
  input wire logic [2:0] chan_load_sel,
  // processor events
  input wire logic div_chk_set,
  input wire logic crt_drum_sel,
  input wire logic copy_exec,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  ////////////////////////////////////////////////////////////////////
  // state
  tsb_regs_t r; // registered state
  tsb_regs_t n; // next state
  logic fin; // execution finishes this cycle
  logic io_set; // any io check cause
  logic [7:0] eot_set; // end-of-tape causes
  logic ac_gt, ac_eq; // signed compare result
  logic lg_gt, lg_eq; // logical compare result
  logic [36:0] ac_mag; // accumulator Q,P,1-35
  logic [36:0] st_mag; // storage magnitude widened
  logic aw_now, w_now; // write halves in hand
  logic [7:0] wa; // write address in hand
  logic [31:0] wd; // write data in hand
  logic ws0; // write strobe lane 0

  ////////////////////////////////////////////////////////////////////
  // outputs from state, the readies gated by ce as well
  assign ins_ready = ce & (r.st == S_IDLE);
  assign done = r.done;
  assign next_ic = r.next_ic;
  assign outcome = r.outcome;
  assign unhandled = r.unhandled;
  assign stor_req = r.stor_req;
  assign stor_addr = r.ea;
  // readies drop with ce so no beat is taken while frozen
  assign s_axi_awready = ce & ~r.aw_got & ~r.bvalid;
  assign s_axi_wready = ce & ~r.w_got & ~r.bvalid;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = ce & ~r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;

  ////////////////////////////////////////////////////////////////////
  // compares, from live accumulator and captured storage word
  always_comb begin
    ac_mag = ac_word[36:0];
    st_mag = {2'h0, r.sword[34:0]};
    if (ac_word[37] != r.sword[35]) begin
      ac_eq = 1'b0;
      ac_gt = ~ac_word[37];
    end else begin
      ac_eq = (ac_mag == st_mag);
      // both minus: larger magnitude is the lower number
      ac_gt = ac_word[37] ? (ac_mag < st_mag) : (ac_mag > st_mag);
    end
    // unsigned 37 bits against 36 bits
    lg_eq = (ac_word[36:0] == {1'b0, r.sword});
    lg_gt = (ac_word[36:0] > {1'b0, r.sword});
  end

  ////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    n = r;
    n.done = 1'b0;
    n.stor_req = 1'b0;
    fin = 1'b0;

    eot_set = chan_wr_active & chan_marker;
    // trap mode off when the operation runs
    io_set = (crt_drum_sel & ~r.ctrl[CTL_SEL_TRAP])
           | (copy_exec & ~r.ctrl[CTL_COPY_TRAP]);
    io_set = io_set | (chan_load_evt & ~chan_busy[chan_load_sel]);
    io_set = io_set | (|chan_underrun) | (|chan_overrun);

    unique case (r.st)
      // take a new instruction and decode it
      S_IDLE: begin
        if (ins_valid) begin
          n.st = S_EXEC;
          n.loc = ins_loc;
          n.ea = ins_addr;
          n.cnt = LEN_1;
          n.have = 1'b0;
          n.need = 1'b0;
          n.len = LEN_2;
          n.chan = 3'h0;
          n.kind = K_NONE;
          // code and modified address chosen together
          if (ins_opcode == OP_IND_MINUS &&
              ins_addr[8:0] == AD_CH_LOW &&
              ins_addr[14:9] >= AD_CH_MIN &&
              ins_addr[14:9] <= AD_CH_MAX) begin
            n.kind = K_END_TAPE;
            // 1000 octal per channel, H wraps to 7
            n.chan = ins_addr[11:9] - 3'h1;
          end else if (ins_opcode == OP_IND_MINUS &&
                       ins_addr == AD_PBIT) begin
            n.kind = K_P_BIT;
          end else if (ins_opcode == OP_IND_PLUS) begin
            // plus indicator tests differ only by address
            if (ins_addr == AD_IO) begin
              n.kind = K_IO_CHECK;
            end else if (ins_addr == AD_LBIT) begin
              n.kind = K_LOW_BIT;
            end else if (ins_addr == AD_DIV) begin
              n.kind = K_DIV_CHECK;
            end
          end else if (ins_opcode == OP_ZERO) begin
            n.kind = K_ZERO;
            n.need = 1'b1;
          end else if (ins_opcode == OP_NONZERO) begin
            n.kind = K_NONZERO;
            n.need = 1'b1;
          end else if (ins_opcode == OP_ARITH) begin
            n.kind = K_ARITH;
            n.need = 1'b1;
            n.len = LEN_3;
          end else if (ins_opcode == OP_LOGIC) begin
            n.kind = K_LOGIC;
            n.need = 1'b1;
            n.len = LEN_3;
          end else if (ins_opcode[10:3] == OP_BUSY_HI) begin
            // minus sign selects the idle form
            n.kind = ins_opcode[11] ? K_CH_IDLE : K_CH_BUSY;
            n.chan = ins_opcode[2:0];
          end else if (ins_opcode[10:2] == OP_EOF_HI) begin
            // channel pair per code, sign picks odd one
            n.kind = K_EOF;
            n.chan = {ins_opcode[1:0], ins_opcode[11]};
          end else if (ins_opcode[10:0] == OP_RC_0 ||
                       ins_opcode[10:0] == OP_RC_1 ||
                       ins_opcode[10:0] == OP_RC_2 ||
                       ins_opcode[10:0] == OP_RC_3) begin
            // irregular code spacing folded to two bits
            n.kind = K_REDUND;
            n.chan[0] = ins_opcode[11];
            n.chan[2] = ins_opcode[2] & ins_opcode[1];
            n.chan[1] = ins_opcode[0] | (ins_opcode[2:1] == 2'h2);
          end
          if (n.kind == K_NONE) begin
            n.len = LEN_1;
          end
          n.stor_req = n.need;
        end
      end
      // count machine cycles and wait for the storage word
      S_EXEC: begin
        if (stor_rvalid && r.need && !r.have) begin
          n.have = 1'b1;
          n.sword = stor_rdata;
        end
        if (r.cnt >= r.len && (!r.need || r.have)) begin
          fin = 1'b1;
          n.st = S_IDLE;
          n.done = 1'b1;
          n.unhandled = (r.kind == K_NONE);
          n.outcome = OUT_SEQ;
          unique case (r.kind)
            // set: clear and proceed; clear: skip
            K_END_TAPE: begin
              if (r.eot[r.chan]) begin
                n.eot[r.chan] = 1'b0;
              end else begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_IO_CHECK: begin
              if (r.io_chk) begin
                n.io_chk = 1'b0;
              end else begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_P_BIT: begin
              if (ac_word[35]) begin
                n.outcome = OUT_SKIP1;
              end
            end
            // bit 35 is the lowest accumulator bit
            K_LOW_BIT: begin
              if (ac_word[0]) begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_DIV_CHECK: begin
              if (r.div_chk) begin
                n.div_chk = 1'b0;
              end else begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_ZERO: begin
              if (r.sword[34:0] == 35'h0) begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_NONZERO: begin
              if (r.sword[34:0] != 35'h0) begin
                n.outcome = OUT_SKIP1;
              end
            end
            K_ARITH: begin
              if (ac_eq) begin
                n.outcome = OUT_SKIP1;
              end else if (!ac_gt) begin
                n.outcome = OUT_SKIP2;
              end
            end
            K_LOGIC: begin
              if (lg_eq) begin
                n.outcome = OUT_SKIP1;
              end else if (!lg_gt) begin
                n.outcome = OUT_SKIP2;
              end
            end
            // only reads busy, never touches the channel
            K_CH_BUSY: begin
              if (chan_busy[r.chan]) begin
                n.outcome = OUT_BRANCH;
              end
            end
            K_CH_IDLE: begin
              if (!chan_busy[r.chan]) begin
                n.outcome = OUT_BRANCH;
              end
            end
            K_REDUND: begin
              if (r.tchk[r.chan]) begin
                n.tchk[r.chan] = 1'b0;
                n.outcome = OUT_BRANCH;
              end
            end
            K_EOF: begin
              if (r.eof[r.chan]) begin
                n.eof[r.chan] = 1'b0;
                n.outcome = OUT_BRANCH;
              end
            end
            // unknown code passes as a no-operation
            K_NONE: begin
              n.outcome = OUT_SEQ;
            end
            default: begin
              n.outcome = OUT_SEQ;
            end
          endcase
          // skips counted from the test's own location
          unique case (n.outcome)
            OUT_SEQ: n.next_ic = r.loc + 15'h0001;
            OUT_SKIP1: n.next_ic = r.loc + 15'h0002;
            OUT_SKIP2: n.next_ic = r.loc + 15'h0003;
            OUT_BRANCH: n.next_ic = r.ea;
          endcase
        end else if (r.cnt != LEN_3) begin
          n.cnt = r.cnt + 2'h1;
        end
      end
    endcase

    // hardware sets win over a test's clear in the same cycle
    n.eot = n.eot | eot_set;
    n.eof = n.eof | chan_eof_set;
    n.tchk = n.tchk | chan_tchk_set;
    n.io_chk = n.io_chk | io_set;
    n.div_chk = n.div_chk | div_chk_set;

    // register bus write: halves in either order
    aw_now = r.aw_got | (s_axi_awvalid & s_axi_awready);
    w_now = r.w_got | (s_axi_wvalid & s_axi_wready);
    wa = r.aw_got ? r.awaddr : s_axi_awaddr;
    wd = r.w_got ? r.wdata : s_axi_wdata;
    ws0 = r.w_got ? r.wstrb0 : s_axi_wstrb[0];
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb0 = s_axi_wstrb[0];
    end
    if (aw_now && w_now && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      // status words are read only; writes there are dropped
      if (wa == R_CTRL) begin
        if (ws0) begin
          n.ctrl = wd[1:0];
        end
      end else if (wa != R_IND && wa != R_CHAN) begin
        n.bresp = RESP_SLVERR;
      end
    end else if (r.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // register bus read
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      n.rdata = 32'h0;
      if (s_axi_araddr == R_CTRL) begin
        n.rdata[1:0] = r.ctrl;
      end else if (s_axi_araddr == R_IND) begin
        n.rdata[1:0] = {r.div_chk, r.io_chk};
      end else if (s_axi_araddr == R_CHAN) begin
        n.rdata = {chan_busy, r.tchk, r.eof, r.eot};
      end else begin
        n.rresp = RESP_SLVERR;
      end
    end else if (r.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // the single state register; ce low freezes it, but reset still loads it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= TSB_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  logic eot_sel, io_sel, div_sel, busy_sel; // helper samples
  assign eot_sel = r.eot[r.chan];
  assign io_sel = r.io_chk;
  assign div_sel = r.div_chk;
  assign busy_sel = chan_busy[r.chan];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  eot_test_a: assert property (
    ce && fin && r.kind == K_END_TAPE |=>
      outcome == ($past(eot_sel) ? OUT_SEQ : OUT_SKIP1))
    else $error("end tape outcome wrong");
  eot_set_a: assert property (
    ce && |eot_set |=> (r.eot & $past(eot_set)) == $past(eot_set))
    else $error("end tape set lost");
  io_test_a: assert property (
    ce && fin && r.kind == K_IO_CHECK && !io_set |=>
      outcome == ($past(io_sel) ? OUT_SEQ : OUT_SKIP1) && !r.io_chk)
    else $error("io check test wrong");
  io_run_a: assert property (
    ce && (|chan_underrun || |chan_overrun) |=> r.io_chk)
    else $error("io check not set");
  div_test_a: assert property (
    ce && fin && r.kind == K_DIV_CHECK |=>
      outcome == ($past(div_sel) ? OUT_SEQ : OUT_SKIP1))
    else $error("divide check outcome wrong");
  arith_len_a: assert property (
    ce && fin && r.kind == K_ARITH |-> r.cnt == LEN_3)
    else $error("compare finished early");
  busy_br_a: assert property (
    ce && fin && r.kind == K_CH_BUSY |=>
      outcome == ($past(busy_sel) ? OUT_BRANCH : OUT_SEQ))
    else $error("busy transfer wrong");
  next_ic_a: assert property (
    done |-> next_ic == (outcome == OUT_BRANCH ? r.ea :
      15'(r.loc + {13'h0, outcome} + 15'h0001)))
    else $error("next location wrong");
  done_pulse_a: assert property (
    ce && done |=> !done)
    else $error("done held too long");

  skip2_c: cover property (done && outcome == OUT_SKIP2);
  branch_c: cover property (done && outcome == OUT_BRANCH);
  unhandled_c: cover property (done && unhandled);
  wr_c: cover property (s_axi_bvalid && s_axi_bready);

endmodule : tsb_unit

`default_nettype wire

//--- bench/tsb_stor_model.sv
// Purpose: core storage side model answering the unit's word reads
// Assumes: one word per request, the bench chooses the word
// Notes: slow stretches the answer to expose waits in the unit
`timescale 1ns/100ps
`default_nettype none

module tsb_stor_model (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request side
  input wire logic stor_req,
  input wire logic slow,
  input wire logic [35:0] word,
  // answer side
  output logic stor_rvalid,
  output logic [35:0] stor_rdata
);
  ////////////////////////////////////////////////////////////
  logic [3:0] wait_r; // counts down from the request, 1 in the answer cycle, 0 when idle

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wait_r <= 4'h0;
    end else if (stor_req) begin
      wait_r <= slow ? 4'h6 : 4'h1;
    end else if (wait_r != 4'h0) begin
      wait_r <= wait_r - 4'h1;
    end
  end

  // data lines never hold a stale word outside the answer cycle
  assign stor_rvalid = (wait_r == 4'h1);
  assign stor_rdata = stor_rvalid ? word : ~word ^ {32'h0, wait_r};
endmodule : tsb_stor_model
`default_nettype wire

//--- bench/test_tsb_unit.sv
// Purpose: self checking bench of the test and skip branch unit
// Assumes: one machine cycle per aclk, ce high but for one freeze
// Notes: every instruction goes through run, registers through axi tasks
`timescale 1ns/100ps
`default_nettype none

module test_tsb_unit
  import tsb_pkg::*;
;
  ////////////////////////////////////////////////////////////
  logic aclk = 1'b0, aresetn = 1'b0, ins_valid = 1'b0, slow = 1'b0;
  logic [11:0] ins_opcode = 12'h000;
  logic [14:0] ins_addr = 15'h0000, ins_loc = 15'h0000, pc = 15'h0100;
  logic [37:0] ac_word = 38'h0;
  logic [35:0] word = 36'h0, stor_rdata;
  logic [7:0] chan_busy = 8'h00, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [7:0] evt [8] = '{default: 8'h00}; // event pulses by kind
  logic [2:0] load_sel = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ce = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ins_ready, done, unhandled, stor_req, stor_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, outcome;
  logic [14:0] next_ic, stor_addr;
  int miscompares = 0, checks_done = 0;

  tsb_unit i_tsb_unit (.aclk, .aresetn, .ce, .ins_valid, .ins_ready,
    .ins_opcode, .ins_addr, .ins_loc, .done, .next_ic, .outcome, .unhandled,
    .ac_word, .stor_req, .stor_addr, .stor_rvalid, .stor_rdata, .chan_busy,
    .chan_wr_active(evt[0]), .chan_marker(evt[1]), .chan_eof_set(evt[2]),
    .chan_tchk_set(evt[3]), .chan_underrun(evt[4]), .chan_overrun(evt[5]),
    .chan_load_evt(|evt[7]), .chan_load_sel(load_sel),
    .div_chk_set(evt[6][1]), .crt_drum_sel(evt[6][2]),
    .copy_exec(evt[6][3]), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tsb_stor_model i_tsb_stor_model (.aclk, .aresetn, .stor_req, .slow, .word,
    .stor_rvalid, .stor_rdata);

  initial forever #20 aclk = ~aclk;

  ////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [37:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 38'(s_axi_bresp), 38'(RESP_OKAY));
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    chk("rdata", 38'(s_axi_rdata), 38'(d));
    chk("rresp", 38'(s_axi_rresp), 38'(r));
  endtask : axi_rd

  // one instruction; cyc 0 skips the length check (storage kinds)
  task automatic run(input logic [11:0] op, input logic [14:0] ad,
    input logic [37:0] ac, input logic [35:0] wd, input logic [1:0] oc,
    input int cyc);
    int n;
    @(posedge aclk);
    ins_opcode <= op;
    ins_addr <= ad;
    ins_loc <= pc;
    ac_word <= ac;
    word <= wd;
    slow <= ~slow;
    ins_valid <= 1'b1;
    do @(posedge aclk); while (ins_ready !== 1'b1);
    ins_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (done !== 1'b1);
    chk("outcome", 38'(outcome), 38'(oc));
    chk("next_ic", 38'(next_ic),
      (oc == OUT_BRANCH) ? 38'(ad) : 38'(pc + 15'(oc) + 15'h1));
    chk("unhandled", 38'(unhandled), 38'(cyc == 1));
    chk("stor_addr", 38'(stor_addr), 38'(ad));
    if (cyc != 0) chk("cycles", 38'(n), 38'(cyc));
    pc = pc + 15'h8;
  endtask : run

  task automatic ev(input int k, input int c);
    @(posedge aclk);
    evt[k][c] <= 1'b1;
    load_sel <= 3'(c);
    @(posedge aclk);
    evt[k][c] <= 1'b0;
  endtask : ev

  ////////////////////////////////////////////////////////////
  int tk [8] = '{6, 6, 6, 6, 7, 7, 4, 5}; // io check event kinds
  int tc [8] = '{2, 3, 2, 3, 0, 1, 3, 6}; // and their bits
  logic [7:0] tset = 8'hE3; // which of them must set io check
  logic [37:0] ta [9] = '{38'h5, 38'h5, 38'h0, 38'h2000000000, 38'h2000000005,
    38'h1000000000, 38'h0, 38'h2800000000, 38'h1000000000};
  logic [35:0] tw [9] = '{36'h3, 36'h5, 36'h800000000, 36'h0, 36'h5,
    36'h7FFFFFFFF, 36'h800000000, 36'h800000000, 36'hFFFFFFFFF};
  logic [1:0] to [9] = '{OUT_SEQ, OUT_SKIP1, OUT_SEQ, OUT_SKIP2, OUT_SKIP2,
    OUT_SEQ, OUT_SKIP2, OUT_SKIP1, OUT_SEQ};
  logic [10:0] rc [4] = '{OP_RC_0, OP_RC_1, OP_RC_2, OP_RC_3};

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    chan_busy <= 8'hA5; // channel busy lines held steady
    axi_rd(R_CTRL, 32'h0, RESP_OKAY);
    axi_rd(8'h0C, 32'h0, RESP_SLVERR);
    axi_wr(R_IND, 32'h3);
    axi_rd(R_IND, 32'h0, RESP_OKAY);
    ev(1, 0);
    run(OP_IND_MINUS, 15'h0200, 38'h0, 36'h0, OUT_SKIP1, 2);
    @(posedge aclk);
    evt[0] <= 8'hFF;
    for (int c = 0; c < 8; c++) begin
      ev(1, c);
      run(OP_IND_MINUS, 15'((c + 1) * 512), 38'h0, 36'h0, OUT_SEQ, 2);
      run(OP_IND_MINUS, 15'((c + 1) * 512), 38'h0, 36'h0, OUT_SKIP1, 2);
    end
    for (int i = 0; i < 8; i++) begin
      if (i == 2) axi_wr(R_CTRL, 32'h3);
      ev(tk[i], tc[i]);
      if (i == 0) axi_rd(R_IND, 32'h1, RESP_OKAY);
      run(OP_IND_PLUS, AD_IO, 38'h0, 36'h0,
        tset[i] ? OUT_SEQ : OUT_SKIP1, 2);
    end
    axi_rd(R_CTRL, 32'h3, RESP_OKAY);
    run(OP_IND_PLUS, AD_IO, 38'h0, 36'h0, OUT_SKIP1, 2);
    ev(6, 1);
    axi_rd(R_IND, 32'h2, RESP_OKAY);
    run(OP_IND_PLUS, AD_DIV, 38'h0, 36'h0, OUT_SEQ, 2);
    run(OP_IND_PLUS, AD_DIV, 38'h0, 36'h0, OUT_SKIP1, 2);
    for (int b = 0; b < 2; b++) begin
      run(OP_IND_MINUS, AD_PBIT, b ? 38'h800000000 : 38'h1, 36'h0,
        b ? OUT_SKIP1 : OUT_SEQ, 2);
      run(OP_IND_PLUS, AD_LBIT, 38'(b) | 38'h800000000, 36'h0,
        b ? OUT_SKIP1 : OUT_SEQ, 2);
      run(OP_ZERO, 15'h0123, 38'h0, b ? 36'h1 : 36'h800000000,
        b ? OUT_SEQ : OUT_SKIP1, 0);
      run(OP_NONZERO, 15'h0123, 38'h0, b ? 36'h1 : 36'h800000000,
        b ? OUT_SKIP1 : OUT_SEQ, 0);
    end
    for (int i = 0; i < 9; i++) begin
      run(i < 6 ? OP_ARITH : OP_LOGIC, 15'h0321, ta[i], tw[i], to[i],
        0);
    end
    for (int c = 0; c < 8; c++) begin
      run({1'b0, 11'h030 + 11'(c)}, 15'h0777, 38'h0, 36'h0,
        chan_busy[c] ? OUT_BRANCH : OUT_SEQ, 2);
      run({1'b1, 11'h030 + 11'(c)}, 15'h0777, 38'h0, 36'h0,
        chan_busy[c] ? OUT_SEQ : OUT_BRANCH, 2);
      ev(3, c);
      run({c[0], rc[c / 2]}, 15'h0555, 38'h0, 36'h0, OUT_BRANCH, 2);
      run({c[0], rc[c / 2]}, 15'h0555, 38'h0, 36'h0, OUT_SEQ, 2);
      ev(2, c);
      run({c[0], 11'h018 + 11'(c / 2)}, 15'h0666, 38'h0, 36'h0,
        OUT_BRANCH, 2);
      run({c[0], 11'h018 + 11'(c / 2)}, 15'h0666, 38'h0, 36'h0,
        OUT_SEQ, 2);
    end
    axi_rd(R_CHAN, 32'hA5000000, RESP_OKAY);
    // a divide check pulse while frozen must be lost
    ce <= 1'b0;
    ev(6, 1);
    ce <= 1'b1;
    run(OP_IND_PLUS, AD_DIV, 38'h0, 36'h0, OUT_SKIP1, 2);
    run(12'h7FF, 15'h0001, 38'h0, 36'h0, OUT_SEQ, 1);
    wrap_up();
  end

  // hang guard, several times the expected run length
  initial begin
    #(40 * 5000);
    miscompares++;
    wrap_up();
  end
endmodule : test_tsb_unit
`default_nettype wire
